// file: monitor_cfg_if.sv
// Carries the stored monitor register bytes from the register file to the monitor logic.
`timescale 1ns/1ps
interface monitor_cfg_if;
    logic [7:0] control;
    logic [7:0] supply_window;
    logic [7:0] pin_one_window;
    logic [7:0] pin_one_level;

    modport regs (output control, output supply_window, output pin_one_window, output pin_one_level);
    modport user (input control, input supply_window, input pin_one_window, input pin_one_level);
endinterface

// file: monitor_deglitch_filter.sv
// One comparator deglitch filter with a run-time selectable settle count.
`timescale 1ns/1ps
module monitor_deglitch_filter
    import vm_types_pkg::*;
#(
    parameter int CNT_W = 13
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic raw,
    input wire logic [CNT_W-1:0] limit,
    output logic filtered
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic out;
    } filter_state_type;

    filter_state_type st;
    filter_state_type next_st;

    // A disabled comparator is held clear so no stale fault survives re-enabling.
    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st = '0; // [RULE16]
        end else if (raw == st.out) begin
            next_st.cnt = '0;
        end else if (st.cnt + CNT_W'(1) >= limit) begin
            next_st.out = raw; // [RULE16]
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + CNT_W'(1);
        end
    end

    // State register.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign filtered = st.out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Clearing on disable also moves the output, so only moves made while enabled must have settled.
    chk_filter_settle_count: assert property ($changed(st.out) && $past(enable) |-> $past(st.cnt) + CNT_W'(1) >= $past(limit)) // [RULE16]
        else $error("Filter output moved before the settle count was reached.");
    chk_filter_disabled_quiet: assert property (!enable |=> !filtered) // [RULE16]
        else $error("Disabled filter still reports a level.");

endmodule // monitor_deglitch_filter

// file: monitor_register_file.sv
// Stores the four monitor configuration registers with serial-port access and non-volatile default load.
`timescale 1ns/1ps
`include "vm_monitor_consts.svh"
module monitor_register_file
    import vm_types_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic nvm_load,
    input wire logic [7:0] nvm_control,
    input wire logic [7:0] nvm_supply_window,
    input wire logic [7:0] nvm_pin_one_window,
    input wire logic [7:0] nvm_pin_one_level,
    monitor_cfg_if.regs cfg
);

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] supply_window;
        logic [7:0] pin_one_window;
        logic [7:0] pin_one_level;
        logic [7:0] rdata;
    } regfile_state_type;

    regfile_state_type st;
    regfile_state_type next_st;

    // Default load beats a write in the same cycle, since defaults are applied only at start-up.
    always_comb begin
        next_st = st;
        if (nvm_load) begin
            next_st.control = nvm_control; // [RULE14]
            next_st.supply_window = nvm_supply_window; // [RULE14]
            next_st.pin_one_window = nvm_pin_one_window; // [RULE14]
            next_st.pin_one_level = nvm_pin_one_level; // [RULE14]
        end else if (reg_write) begin
            unique case (reg_addr)
                `VM_CONTROL_OFFSET: next_st.control = reg_wdata;
                `VM_SUPPLY_WINDOW_OFFSET: next_st.supply_window = reg_wdata;
                `VM_PIN_ONE_WINDOW_OFFSET: next_st.pin_one_window = reg_wdata;
                `VM_PIN_ONE_LEVEL_OFFSET: next_st.pin_one_level = reg_wdata; // [RULE15]
                default: next_st.control = st.control;
            endcase
        end
        if (reg_read) begin
            unique case (reg_addr)
                `VM_CONTROL_OFFSET: next_st.rdata = st.control;
                `VM_SUPPLY_WINDOW_OFFSET: next_st.rdata = st.supply_window;
                `VM_PIN_ONE_WINDOW_OFFSET: next_st.rdata = st.pin_one_window;
                `VM_PIN_ONE_LEVEL_OFFSET: next_st.rdata = st.pin_one_level;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // State register; hardware reset gives zeros until the defaults are loaded.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= {5{`VM_REG_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign cfg.control = st.control;
    assign cfg.supply_window = st.supply_window;
    assign cfg.pin_one_window = st.pin_one_window;
    assign cfg.pin_one_level = st.pin_one_level;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_level_write;
        reg_write && !nvm_load && reg_addr == `VM_PIN_ONE_LEVEL_OFFSET;
    endsequence

    sequence s_level_read;
        reg_read && !reg_write && !nvm_load && reg_addr == `VM_PIN_ONE_LEVEL_OFFSET;
    endsequence

    chk_nvm_default_load: assert property (nvm_load |=> cfg.control == $past(nvm_control)
            && cfg.pin_one_window == $past(nvm_pin_one_window)) // [RULE14]
        else $error("Defaults were not taken from non-volatile memory.");
    chk_level_readback: assert property (s_level_write ##1 s_level_read |=> reg_rdata == $past(reg_wdata, 2)) // [RULE15]
        else $error("Pin one level did not read back as written.");
    chk_control_write: assert property (reg_write && !nvm_load && reg_addr == `VM_CONTROL_OFFSET
            |=> cfg.control == $past(reg_wdata)) // [RULE2]
        else $error("Control register write was lost.");

endmodule // monitor_register_file

// file: vm_monitor_consts.svh
// Offsets, field positions, reset values and deglitch timing of the voltage monitor registers.
`ifndef VM_MONITOR_CONSTS_SVH
`define VM_MONITOR_CONSTS_SVH

`define VM_CONTROL_OFFSET 8'h2b
`define VM_SUPPLY_WINDOW_OFFSET 8'h2c
`define VM_PIN_ONE_WINDOW_OFFSET 8'h2d
`define VM_PIN_ONE_LEVEL_OFFSET 8'h2e
`define VM_REG_RESET 8'h00

`define VM_DEGLITCH_HI 7
`define VM_DEGLITCH_LO 5
`define VM_PIN_TWO_RESIDUAL_BIT 4
`define VM_PIN_TWO_ENABLE_BIT 3
`define VM_PIN_ONE_RESIDUAL_BIT 2
`define VM_PIN_ONE_ENABLE_BIT 1
`define VM_SUPPLY_ENABLE_BIT 0
`define VM_NOMINAL_BIT 6
`define VM_RANGE_BIT 6
`define VM_LOW_HI 5
`define VM_LOW_LO 3
`define VM_HIGH_HI 2
`define VM_HIGH_LO 0

`define VM_CLK_MHZ 250
`define VM_DEGLITCH_SHORT_NS 500
`define VM_DEGLITCH_MID_NS 4000
`define VM_DEGLITCH_LONG_NS 20000
`define VM_DEGLITCH_SHORT_CYC ((`VM_DEGLITCH_SHORT_NS * `VM_CLK_MHZ + 999) / 1000)
`define VM_DEGLITCH_MID_CYC ((`VM_DEGLITCH_MID_NS * `VM_CLK_MHZ + 999) / 1000)
`define VM_DEGLITCH_LONG_CYC ((`VM_DEGLITCH_LONG_NS * `VM_CLK_MHZ + 999) / 1000)

`endif

// file: vm_types_pkg.sv
// Types and decode functions shared by the voltage monitor configuration logic.
package vm_types_pkg;

    typedef enum logic [2:0] {
        DG_SHORT = 3'h1,
        DG_MID = 3'h2,
        DG_LONG = 3'h4
    } deglitch_time_type;

    typedef struct packed {
        deglitch_time_type supply;
        deglitch_time_type converter;
        deglitch_time_type pin;
    } deglitch_plan_type;

    // Deglitch select code to the time used by each monitor class.
    function automatic deglitch_plan_type decode_deglitch(input logic [2:0] code);
        deglitch_plan_type p;
        unique case (code)
            3'h0: p = '{DG_MID, DG_MID, DG_MID};
            3'h1: p = '{DG_LONG, DG_LONG, DG_LONG};
            3'h2: p = '{DG_SHORT, DG_SHORT, DG_SHORT};
            3'h3: p = '{DG_MID, DG_SHORT, DG_SHORT};
            3'h4: p = '{DG_LONG, DG_SHORT, DG_SHORT};
            3'h5: p = '{DG_SHORT, DG_MID, DG_MID};
            3'h6: p = '{DG_MID, DG_MID, DG_MID};
            3'h7: p = '{DG_LONG, DG_MID, DG_MID};
        endcase
        return p;
    endfunction

    // Threshold ladder in millivolts (pins) or tenths of a percent (supply); extended range is five times wider.
    function automatic logic [9:0] threshold_step(input logic [2:0] code, input logic extended);
        logic [9:0] base;
        unique case (code)
            3'h0: base = 10'h01e;
            3'h1: base = 10'h023;
            3'h2: base = 10'h028;
            3'h3: base = 10'h032;
            3'h4: base = 10'h03c;
            3'h5: base = 10'h046;
            3'h6: base = 10'h050;
            3'h7: base = 10'h064;
        endcase
        return extended ? 10'(base * 10'h005) : base;
    endfunction

endpackage

// file: voltage_monitor_config_regs.sv
// Voltage monitor configuration registers, field decode and deglitched comparator fault reporting.
// How it works
// RULE1: Control bits 7:5 pick deglitch time per class from 4, 20 or 0.5 us.
// RULE2: Control bit 4 enables residual voltage checking on monitor pin two.
// RULE3: Control bit 3 enables both comparators of monitor pin two.
// RULE4: Control bit 2 enables residual voltage checking on monitor pin one.
// RULE5: Control bit 1 enables both comparators of monitor pin one.
// RULE6: Control bit 0 enables both comparators of the analog supply input.
// RULE7: Supply window bit 6 selects nominal level, 0 for 3.3 V, 1 for 5.0 V.
// RULE8: Supply window bits 5:3 give low threshold from -3% to -10%.
// RULE9: Supply window bits 2:0 give high threshold from +3% to +10%.
// RULE10: Pin one window bit 6 selects normal or extended monitoring range.
// RULE11: Pin one window bits 5:3 give low threshold, -30 mV to -100 mV.
// RULE12: Pin one window bits 2:0 give high threshold, +30 mV to +100 mV.
// RULE13: Extended range scales pin thresholds fivefold, 150 mV up to 500 mV.
// RULE14: Every field takes its start value from non-volatile memory defaults.
// RULE15: Pin one level register holds an eight-bit nominal level code.
// RULE16: Disabled comparators never fault; enabled ones report only through the deglitch filter.
`timescale 1ns/1ps
`include "vm_monitor_consts.svh"
module voltage_monitor_config_regs
    import vm_types_pkg::*;
#(
    parameter int N_CONV = 4,
    parameter int LONG_DEGLITCH_CYCLES = `VM_DEGLITCH_LONG_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic nvm_load,
    input wire logic [7:0] nvm_control,
    input wire logic [7:0] nvm_supply_window,
    input wire logic [7:0] nvm_pin_one_window,
    input wire logic [7:0] nvm_pin_one_level,
    input wire logic supply_ov_raw,
    input wire logic supply_uv_raw,
    input wire logic pin_one_ov_raw,
    input wire logic pin_one_uv_raw,
    input wire logic pin_two_ov_raw,
    input wire logic pin_two_uv_raw,
    input wire logic [N_CONV-1:0] converter_ov_raw,
    input wire logic [N_CONV-1:0] converter_uv_raw,
    input wire logic [N_CONV-1:0] converter_monitor_enable,
    output logic supply_comparator_enable,
    output logic pin_one_comparator_enable,
    output logic pin_two_comparator_enable,
    output logic pin_one_residual_check,
    output logic pin_two_residual_check,
    output logic supply_nominal_level,
    output logic pin_one_range_select,
    output logic [7:0] pin_one_nominal_level,
    output logic [2:0] supply_low_threshold,
    output logic [2:0] supply_high_threshold,
    output logic [2:0] pin_one_low_threshold,
    output logic [2:0] pin_one_high_threshold,
    output logic [9:0] supply_low_tenths_pct,
    output logic [9:0] supply_high_tenths_pct,
    output logic [9:0] pin_one_low_offset_mv,
    output logic [9:0] pin_one_high_offset_mv,
    output logic supply_ov_fault,
    output logic supply_uv_fault,
    output logic pin_one_ov_fault,
    output logic pin_one_uv_fault,
    output logic pin_two_ov_fault,
    output logic pin_two_uv_fault,
    output logic [N_CONV-1:0] converter_ov_fault,
    output logic [N_CONV-1:0] converter_uv_fault
);

    localparam int NCH = 6 + 2 * N_CONV;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'(`VM_DEGLITCH_SHORT_CYC);
    localparam logic [CNT_W-1:0] MID_CYC = CNT_W'(`VM_DEGLITCH_MID_CYC);
    localparam logic [CNT_W-1:0] LONG_CYC = CNT_W'(LONG_DEGLITCH_CYCLES);

    typedef struct packed {
        logic [9:0] supply_low;
        logic [9:0] supply_high;
        logic [9:0] pin_low;
        logic [9:0] pin_high;
        logic [NCH-1:0] fault;
    } monitor_state_type;

    monitor_state_type st;
    monitor_state_type next_st;
    deglitch_plan_type plan;
    logic [CNT_W-1:0] supply_limit;
    logic [CNT_W-1:0] converter_limit;
    logic [CNT_W-1:0] pin_limit;
    logic [NCH-1:0] raw_vec;
    logic [NCH-1:0] en_vec;
    logic [NCH-1:0] filt_vec;

    monitor_cfg_if cfg ();

    // Register storage and the serial-port access path live in their own module.
    monitor_register_file u_regs (
        .core_clk(core_clk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_write(reg_write),
        .reg_wdata(reg_wdata),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .nvm_load(nvm_load),
        .nvm_control(nvm_control),
        .nvm_supply_window(nvm_supply_window),
        .nvm_pin_one_window(nvm_pin_one_window),
        .nvm_pin_one_level(nvm_pin_one_level),
        .cfg(cfg.regs)
    );

    // Control and window fields go straight out; they are already register bits.
    assign supply_comparator_enable = cfg.control[`VM_SUPPLY_ENABLE_BIT]; // [RULE6]
    assign pin_one_comparator_enable = cfg.control[`VM_PIN_ONE_ENABLE_BIT]; // [RULE5]
    assign pin_two_comparator_enable = cfg.control[`VM_PIN_TWO_ENABLE_BIT]; // [RULE3]
    assign pin_one_residual_check = cfg.control[`VM_PIN_ONE_RESIDUAL_BIT]; // [RULE4]
    assign pin_two_residual_check = cfg.control[`VM_PIN_TWO_RESIDUAL_BIT]; // [RULE2]
    assign supply_nominal_level = cfg.supply_window[`VM_NOMINAL_BIT]; // [RULE7]
    assign pin_one_range_select = cfg.pin_one_window[`VM_RANGE_BIT]; // [RULE10]
    assign pin_one_nominal_level = cfg.pin_one_level; // [RULE15]
    assign supply_low_threshold = cfg.supply_window[`VM_LOW_HI:`VM_LOW_LO]; // [RULE8]
    assign supply_high_threshold = cfg.supply_window[`VM_HIGH_HI:`VM_HIGH_LO]; // [RULE9]
    assign pin_one_low_threshold = cfg.pin_one_window[`VM_LOW_HI:`VM_LOW_LO]; // [RULE11]
    assign pin_one_high_threshold = cfg.pin_one_window[`VM_HIGH_HI:`VM_HIGH_LO]; // [RULE12]

    // Per-class settle counts; the long count is a parameter so simulation can shorten it.
    function automatic logic [CNT_W-1:0] limit_of(input deglitch_time_type t);
        logic [CNT_W-1:0] lim;
        unique case (t)
            DG_SHORT: lim = SHORT_CYC;
            DG_MID: lim = MID_CYC;
            DG_LONG: lim = LONG_CYC;
            default: lim = MID_CYC;
        endcase
        return lim;
    endfunction

    // Deglitch selection is decoded once and shared by every channel of a class.
    always_comb begin
        plan = decode_deglitch(cfg.control[`VM_DEGLITCH_HI:`VM_DEGLITCH_LO]); // [RULE1]
        supply_limit = limit_of(plan.supply); // [RULE1]
        converter_limit = limit_of(plan.converter); // [RULE1]
        pin_limit = limit_of(plan.pin); // [RULE1]
    end

    // Channel order: supply, pin one, pin two, then converter high and low groups.
    assign raw_vec = {converter_uv_raw, converter_ov_raw, pin_two_uv_raw, pin_two_ov_raw,
                      pin_one_uv_raw, pin_one_ov_raw, supply_uv_raw, supply_ov_raw};
    assign en_vec = {converter_monitor_enable, converter_monitor_enable,
                     {2{cfg.control[`VM_PIN_TWO_ENABLE_BIT]}}, // [RULE3]
                     {2{cfg.control[`VM_PIN_ONE_ENABLE_BIT]}}, // [RULE5]
                     {2{cfg.control[`VM_SUPPLY_ENABLE_BIT]}}}; // [RULE6]

    // One filter per comparator output.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_filter
            monitor_deglitch_filter #(
                .CNT_W(CNT_W)
            ) u_filter (
                .core_clk(core_clk),
                .srst(srst),
                .enable(en_vec[gi]),
                .raw(raw_vec[gi]),
                .limit((gi < 2) ? supply_limit : ((gi < 6) ? pin_limit : converter_limit)),
                .filtered(filt_vec[gi])
            );
        end
    endgenerate

    // Threshold decode and fault gating; gating here too drops a fault on the edge after its enable clears.
    always_comb begin
        next_st = st;
        next_st.supply_low = threshold_step(supply_low_threshold, 1'b0); // [RULE8]
        next_st.supply_high = threshold_step(supply_high_threshold, 1'b0); // [RULE9]
        next_st.pin_low = threshold_step(pin_one_low_threshold, pin_one_range_select); // [RULE11] [RULE13]
        next_st.pin_high = threshold_step(pin_one_high_threshold, pin_one_range_select); // [RULE12] [RULE13]
        next_st.fault = filt_vec & en_vec; // [RULE16]
    end

    // State register.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign supply_low_tenths_pct = st.supply_low;
    assign supply_high_tenths_pct = st.supply_high;
    assign pin_one_low_offset_mv = st.pin_low;
    assign pin_one_high_offset_mv = st.pin_high;
    assign supply_ov_fault = st.fault[0];
    assign supply_uv_fault = st.fault[1];
    assign pin_one_ov_fault = st.fault[2];
    assign pin_one_uv_fault = st.fault[3];
    assign pin_two_ov_fault = st.fault[4];
    assign pin_two_uv_fault = st.fault[5];
    assign converter_ov_fault = st.fault[6 +: N_CONV];
    assign converter_uv_fault = st.fault[6 + N_CONV +: N_CONV];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_short_pins;
        cfg.control[`VM_DEGLITCH_HI:`VM_DEGLITCH_LO] == 3'h2;
    endsequence

    sequence s_supply_long;
        cfg.control[`VM_DEGLITCH_HI:`VM_DEGLITCH_LO] == 3'h4;
    endsequence

    chk_short_deglitch_map: assert property (s_short_pins |-> pin_limit == SHORT_CYC && supply_limit == SHORT_CYC) // [RULE1]
        else $error("Code two did not select the short deglitch time.");
    chk_mixed_deglitch_map: assert property (s_supply_long |-> supply_limit == LONG_CYC && pin_limit == SHORT_CYC) // [RULE1]
        else $error("Code four did not split long supply and short pin times.");
    chk_supply_gate: assert property (!cfg.control[`VM_SUPPLY_ENABLE_BIT] |=> !supply_ov_fault && !supply_uv_fault) // [RULE6]
        else $error("Disabled supply comparator reported a fault.");
    chk_pin_one_gate: assert property (!cfg.control[`VM_PIN_ONE_ENABLE_BIT] |=> !pin_one_ov_fault && !pin_one_uv_fault) // [RULE5]
        else $error("Disabled pin one comparator reported a fault.");
    chk_pin_two_gate: assert property (!cfg.control[`VM_PIN_TWO_ENABLE_BIT] |=> !pin_two_ov_fault && !pin_two_uv_fault) // [RULE3]
        else $error("Disabled pin two comparator reported a fault.");
    chk_supply_window_top: assert property (supply_low_threshold == 3'h7 && supply_high_threshold == 3'h0
            |=> supply_low_tenths_pct == 10'h064 && supply_high_tenths_pct == 10'h01e) // [RULE8] [RULE9]
        else $error("Supply window ladder decoded wrongly.");
    chk_pin_normal_range: assert property (!pin_one_range_select && pin_one_low_threshold == 3'h0
            && pin_one_high_threshold == 3'h7 |=> pin_one_low_offset_mv == 10'h01e && pin_one_high_offset_mv == 10'h064) // [RULE11] [RULE12]
        else $error("Pin one normal range ladder decoded wrongly.");
    chk_pin_extended_range: assert property (pin_one_range_select && pin_one_low_threshold == 3'h7
            && pin_one_high_threshold == 3'h0 |=> pin_one_low_offset_mv == 10'h1f4 && pin_one_high_offset_mv == 10'h096) // [RULE13]
        else $error("Pin one extended range was not scaled fivefold.");
    chk_fault_needs_filter: assert property ($rose(supply_ov_fault) |-> $past(filt_vec[0])) // [RULE16]
        else $error("Supply fault rose without a filtered comparator level.");

endmodule // voltage_monitor_config_regs

// file: voltage_monitor_config_regs_tb.sv
// Self-checking testbench for the voltage monitor configuration registers.
`timescale 1ns/1ps
module voltage_monitor_config_regs_tb;
    localparam int LONG = 20;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_write = 1'b0, reg_read = 1'b0, nvm_load = 1'b0;
    logic [7:0] nvm_control = 8'h00, nvm_supply_window = 8'h00, nvm_pin_one_window = 8'h00, nvm_pin_one_level = 8'h00;
    logic supply_ov_raw = 1'b0, supply_uv_raw = 1'b0, pin_one_ov_raw = 1'b0, pin_one_uv_raw = 1'b0;
    logic pin_two_ov_raw = 1'b0, pin_two_uv_raw = 1'b0;
    logic [3:0] converter_ov_raw = 4'h0, converter_uv_raw = 4'h0, converter_monitor_enable = 4'h0;
    logic supply_comparator_enable, pin_one_comparator_enable, pin_two_comparator_enable;
    logic pin_one_residual_check, pin_two_residual_check, supply_nominal_level, pin_one_range_select;
    logic [7:0] pin_one_nominal_level;
    logic [2:0] supply_low_threshold, supply_high_threshold, pin_one_low_threshold, pin_one_high_threshold;
    logic [9:0] supply_low_tenths_pct, supply_high_tenths_pct, pin_one_low_offset_mv, pin_one_high_offset_mv;
    logic supply_ov_fault, supply_uv_fault, pin_one_ov_fault, pin_one_uv_fault, pin_two_ov_fault, pin_two_uv_fault;
    logic [3:0] converter_ov_fault, converter_uv_fault;
    logic [7:0] mdl [4] = '{default: 8'h00};
    int num_errors = 0;
    int tests_run = 0;
    int seed = 32'hb286;
    // Settle counts per deglitch code; the long class is shortened by parameter to keep the run brief.
    int sup_lim [8] = '{1000, LONG, 125, 1000, LONG, 125, 1000, LONG};
    int pin_lim [8] = '{1000, LONG, 125, 125, 125, 1000, 1000, 1000};

    voltage_monitor_config_regs #(.N_CONV(4), .LONG_DEGLITCH_CYCLES(LONG)) DUT (.*);

    // Free-running 250 MHz clock.
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // Threshold ladder worked out independently; the extended range is five times wider.
    function automatic logic [9:0] ladder(input logic [2:0] c, input logic x);
        logic [9:0] t [8] = '{10'h01e, 10'h023, 10'h028, 10'h032, 10'h03c, 10'h046, 10'h050, 10'h064};
        return x ? 10'(t[c] * 10'h005) : t[c];
    endfunction

    task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic check_all();
        check(supply_comparator_enable, mdl[0][0], "supply enable");
        check(pin_one_comparator_enable, mdl[0][1], "pin one enable");
        check(pin_one_residual_check, mdl[0][2], "pin one residual");
        check(pin_two_comparator_enable, mdl[0][3], "pin two enable");
        check(pin_two_residual_check, mdl[0][4], "pin two residual");
        check(supply_nominal_level, mdl[1][6], "supply nominal");
        check({supply_low_threshold, supply_high_threshold}, mdl[1][5:0], "supply codes");
        check(supply_low_tenths_pct, ladder(mdl[1][5:3], 1'b0), "supply low");
        check(supply_high_tenths_pct, ladder(mdl[1][2:0], 1'b0), "supply high");
        check(pin_one_range_select, mdl[2][6], "pin range");
        check({pin_one_low_threshold, pin_one_high_threshold}, mdl[2][5:0], "pin codes");
        check(pin_one_low_offset_mv, ladder(mdl[2][5:3], mdl[2][6]), "pin low");
        check(pin_one_high_offset_mv, ladder(mdl[2][2:0], mdl[2][6]), "pin high");
        check(pin_one_nominal_level, mdl[3], "pin level");
    endtask

    // One write; the trailing idle edge keeps back-to-back calls from driving the strobe twice at once.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        if (a >= 8'h2b && a <= 8'h2e) mdl[2'(a - 8'h2b)] = d;
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        #1 check(reg_rdata, e, "read back");
    endtask

    // Raise every comparator and watch each class settle at its own count for deglitch code k.
    task automatic fault_run(input logic [2:0] k);
        int ls;
        int lp;
        ls = sup_lim[k];
        lp = pin_lim[k];
        wr(8'h2b, {k, 1'b1, k[0], 3'b111});
        {supply_ov_raw, supply_uv_raw, pin_one_ov_raw, pin_one_uv_raw, pin_two_ov_raw, pin_two_uv_raw} <= 6'h3f;
        {converter_ov_raw, converter_uv_raw} <= 8'hff;
        converter_monitor_enable <= 4'hf;
        // The fault is first seen one edge after the filter has counted its full settle time.
        for (int n = 1; n <= 1003; n++) begin
            @(posedge core_clk);
            #1;
            if (n == ls || n == ls + 1) check({supply_ov_fault, supply_uv_fault}, {2{n > ls}}, "supply fault");
            if (n == lp || n == lp + 1) check({pin_one_ov_fault, pin_one_uv_fault, converter_ov_fault, converter_uv_fault},
                {10{n > lp}}, "pin fault");
        end
        check({pin_two_ov_fault, pin_two_uv_fault}, 10'({2{k[0]}}), "pin two follows enable");
        wr(8'h2b, {k, 5'b00000});
        @(posedge core_clk);
        #1 check({supply_ov_fault, supply_uv_fault, pin_one_ov_fault, pin_one_uv_fault, pin_two_ov_fault, pin_two_uv_fault},
            10'h000, "disabled");
        {supply_ov_raw, supply_uv_raw, pin_one_ov_raw, pin_one_uv_raw, pin_two_ov_raw, pin_two_uv_raw} <= 6'h00;
        {converter_ov_raw, converter_uv_raw} <= 8'h00;
        converter_monitor_enable <= 4'h0;
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset values, default load, random register traffic, then the fault path.
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) rd(8'(8'h2b + i), 8'h00);
        check_all();
        // A write in the load cycle must lose to the defaults.
        @(posedge core_clk);
        nvm_control <= 8'($random(seed));
        nvm_supply_window <= 8'($random(seed));
        nvm_pin_one_window <= 8'($random(seed));
        nvm_pin_one_level <= 8'($random(seed));
        {nvm_load, reg_write, reg_addr, reg_wdata} <= {2'b11, 8'h2e, 8'ha5};
        @(posedge core_clk);
        {nvm_load, reg_write} <= 2'b00;
        mdl = '{nvm_control, nvm_supply_window, nvm_pin_one_window, nvm_pin_one_level};
        @(posedge core_clk);
        #1 check_all();
        repeat (40) begin
            a = 8'(8'h2b + $unsigned($random(seed)) % 5);
            d = 8'($random(seed));
            wr(a, d);
            check_all();
            rd(a, (a == 8'h2f) ? 8'h00 : d);
        end
        for (int k = 0; k < 8; k++) fault_run(3'(k));
        wrap_up();
    end

    // Watchdog sized well above the expected run of roughly eight thousand cycles.
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end
endmodule // voltage_monitor_config_regs_tb
